// ### rtl/dpw_cfg.svh
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// Register byte offsets.
`define DPW_OFF_PWRCTL     8'h00
`define DPW_OFF_AHBCLK     8'h04
`define DPW_OFF_APBCLK     8'h08
`define DPW_OFF_KEEPSTATE  8'h0c
`define DPW_OFF_CLKSEL0    8'h10
`define DPW_OFF_CLKSEL1    8'h14
`define DPW_OFF_CLKDIV     8'h18
`define DPW_OFF_CLKSEL2    8'h1c
`define DPW_OFF_SLEEPGATE  8'h20
`define DPW_OFF_PWRFLAGS   8'h24
`define DPW_OFF_DBGPD      8'h28
`define DPW_OFF_IRQ_STATUS 8'h2c
`define DPW_OFF_IRQ_MASK   8'h30

// Power-control field positions.
`define DPW_PC_STATUS_LSB  28
`define DPW_PC_POR_FLAG    26
`define DPW_PC_TMR_FLAG    25
`define DPW_PC_PIN_FLAG    24
`define DPW_PC_SELECT_LSB  20
`define DPW_PC_OSC_OFF     17
`define DPW_PC_PIN_DIS     16
`define DPW_PC_DEEP_REQ    11
`define DPW_PC_STBY_REQ    10
`define DPW_PC_OSC_EN_LSB  1

// Debug power-down disable bit in the debug register.
`define DPW_DBG_DISABLE    0

// Reset values.
`define DPW_RST_PWRCTL_OSC 3'h3
`define DPW_RST_AHBCLK     32'h00000005
`define DPW_RST_APBCLK     32'h00000000
`define DPW_RST_KEEPSTATE  32'h00000000
`define DPW_RST_CLKSEL0    32'h00000038
`define DPW_RST_CLKSEL1    32'h3300771f
`define DPW_RST_CLKDIV     32'h00000000
`define DPW_RST_CLKSEL2    32'hfffffff0
`define DPW_RST_SLEEPGATE  32'h0fffffff
`define DPW_RST_PWRFLAGS   32'h00000000
`define DPW_RST_DBGPD      32'h00000000

// Slow oscillator cycle counts for each timer select bit.
`define DPW_WAKE_CNT0      11'h080
`define DPW_WAKE_CNT1      11'h100
`define DPW_WAKE_CNT2      11'h200
`define DPW_WAKE_CNT3      11'h400

// Interrupt status bit positions.
`define DPW_IRQ_DEEP_WAKE  0
`define DPW_IRQ_STBY_WAKE  1
`define DPW_IRQ_REFUSED    2
`define DPW_IRQ_LOCKED_WR  3

`endif

// ### rtl/dpw_pkg.sv
package dpw_pkg;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } dpw_apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dpw_apb_rsp_t;

  // Power mode, one-hot.
  typedef enum logic [2:0] {
    DPW_RUN     = 3'b001,
    DPW_DEEP    = 3'b010,
    DPW_STANDBY = 3'b100
  } dpw_mode_t;

  // Power pin and status outputs.
  typedef struct packed {
    logic deepdown_active;
    logic standby_active;
    logic slow_osc_run;
    logic fast_osc_enable;
    logic crystal_enable;
  } dpw_power_out_t;

endpackage

// ### rtl/dpw_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of asynchronous levels.
module dpw_sync #(
  parameter int          WIDTH     = 4,
  parameter logic [3:0]  RESET_VAL = 4'h0
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // Levels in and out.
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dpw_sync_state_t;

  dpw_sync_state_t state;
  dpw_sync_state_t next_state;

  // Only the second stage looks at the first, to keep metastability contained.
  always_comb
  begin
    next_state.stage1 = i_async;
    next_state.stage2 = state.stage1;
  end

  // Register both stages.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state.stage1 <= RESET_VAL[WIDTH-1:0];
      state.stage2 <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_sync = state.stage2;

endmodule

`default_nettype wire

// ### rtl/dpw_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpw_cfg.svh"

// Operation
// - Bits 31 to 28 read back the wake-timer select as latched on entry to deepest power-down.
// - Bit 26 is set when the last deepest power-down wakeup came from a power-on event.
// - Bit 25 is set when the last wakeup came from the slow oscillator timer.
// - Bit 24 is set when the last wakeup came from a falling edge on the wake pin.
// - All three wake flags clear whenever deepest power-down is entered.
// - Select bits 23 to 20; bit 0 wakes after 128 slow cycles, bit 1 after 256.
// - Select bit 2 wakes after 512 slow cycles, bit 3 after 1024.
// - Bit 17 at 0 keeps the slow oscillator on in deepest power-down, at 1 stops it and any timed wake.
// - Bit 16 decides whether the wake pin may wake the device from deepest power-down.
// - The power-control register ignores writes while protection is locked.
// - Eleven 32-bit clock-controller registers are decoded at offsets 0x00 to 0x28.
// - Bit 11 is the deepest power-down request and bit 10 the standby request.
// - Deepest request set and a wait-for-interrupt or event enters deepest power-down.
// - Standby request set and a wait-for-interrupt or event enters standby power-down; with bit 11 also set the code enters deepest power-down instead.
// - The wake-pin bit is active low: 0 enables pin wakeup, 1 disables it.
module dpw_power_ctrl
  import dpw_pkg::*;
(
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // APB slave.
  input  wire dpw_pkg::dpw_apb_req_t i_apb,
  output var  dpw_pkg::dpw_apb_rsp_t o_apb,
  // Core and protection status, same clock.
  input  wire logic                  i_prot_unlocked,
  input  wire logic                  i_core_sleep,
  input  wire logic                  i_debug_active,
  // Asynchronous pins.
  input  wire logic                  i_wake_pin,
  input  wire logic                  i_slow_osc_clk,
  input  wire logic                  i_por_event,
  input  wire logic                  i_standby_wake,
  // Power outputs and interrupt.
  output var  dpw_pkg::dpw_power_out_t o_power,
  output logic                       o_irq
);
  import dpw_pkg::*;

  localparam int NUM_BANK = 10;

  typedef struct packed {
    dpw_mode_t                     mode;
    logic [3:0]                    wake_timer_status;
    logic                          power_on_wake_flag;
    logic                          timer_wake_flag;
    logic                          pin_wake_flag;
    logic [3:0]                    wake_timer_select;
    logic                          slow_osc_off_in_deepdown;
    logic                          wake_pin_disable;
    logic                          deepest_powerdown_request;
    logic                          standby_powerdown_request;
    logic [2:0]                    osc_enables;
    logic [NUM_BANK-1:0][31:0]     bank;
    logic [10:0]                   slow_count;
    logic                          slow_prev;
    logic                          pin_prev;
    logic [3:0]                    irq_status;
    logic [3:0]                    irq_mask;
    dpw_apb_rsp_t                  rsp;
    dpw_power_out_t                pwr;
    logic                          irq;
  } dpw_state_t;

  // Plain storage registers, offsets 0x04 to 0x28 in order.
  localparam logic [NUM_BANK-1:0][31:0] BANK_RESET = {
    `DPW_RST_DBGPD, `DPW_RST_PWRFLAGS, `DPW_RST_SLEEPGATE, `DPW_RST_CLKSEL2,
    `DPW_RST_CLKDIV, `DPW_RST_CLKSEL1, `DPW_RST_CLKSEL0, `DPW_RST_KEEPSTATE,
    `DPW_RST_APBCLK, `DPW_RST_AHBCLK
  };

  localparam dpw_state_t RESET_STATE = '{
    mode:                      DPW_RUN,
    wake_timer_status:         4'h0,
    power_on_wake_flag:        1'b0,
    timer_wake_flag:           1'b0,
    pin_wake_flag:             1'b0,
    wake_timer_select:         4'h0,
    slow_osc_off_in_deepdown:  1'b0,
    wake_pin_disable:          1'b0,
    deepest_powerdown_request: 1'b0,
    standby_powerdown_request: 1'b0,
    osc_enables:               `DPW_RST_PWRCTL_OSC,
    bank:                      BANK_RESET,
    slow_count:                11'h000,
    slow_prev:                 1'b0,
    pin_prev:                  1'b1,
    irq_status:                4'h0,
    irq_mask:                  4'h0,
    rsp:                       '0,
    pwr:                       '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
    irq:                       1'b0
  };

  dpw_state_t state;
  dpw_state_t next_state;
  logic [3:0] pins_sync;
  logic       por_s;
  logic       pin_s;
  logic       slow_s;
  logic       stby_s;

  // Every pin passes two flops; the wake pin idles high.
  dpw_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'h4)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_por_event, i_wake_pin, i_slow_osc_clk, i_standby_wake}),
    .o_sync   (pins_sync)
  );

  assign {por_s, pin_s, slow_s, stby_s} = pins_sync;

  // Merge write data into an old word under the byte strobes.
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Assemble the power-control word from its fields.
  function automatic logic [31:0] pwrctl_word(input dpw_state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    w[`DPW_PC_STATUS_LSB +: 4] = s.wake_timer_status;
    w[`DPW_PC_POR_FLAG]        = s.power_on_wake_flag;
    w[`DPW_PC_TMR_FLAG]        = s.timer_wake_flag;
    w[`DPW_PC_PIN_FLAG]        = s.pin_wake_flag;
    w[`DPW_PC_SELECT_LSB +: 4] = s.wake_timer_select;
    w[`DPW_PC_OSC_OFF]         = s.slow_osc_off_in_deepdown;
    w[`DPW_PC_PIN_DIS]         = s.wake_pin_disable;
    w[`DPW_PC_DEEP_REQ]        = s.deepest_powerdown_request;
    w[`DPW_PC_STBY_REQ]        = s.standby_powerdown_request;
    w[`DPW_PC_OSC_EN_LSB +: 3] = s.osc_enables;
    return w;
  endfunction

  // Next-state logic for the bus, the power modes and the wake sources.
  always_comb
  begin
    logic        setup;
    logic        access;
    logic        mapped;
    logic        aligned;
    logic [5:0]  widx;
    logic [31:0] rdata;
    logic [31:0] wword;
    logic [10:0] count_inc;
    logic        slow_rise;
    logic        pin_fall;
    logic        timer_hit;
    logic        pd_blocked;
    logic [3:0]  events;
    logic        locked_wr;

    next_state = state;
    setup      = i_apb.psel && !i_apb.penable;
    access     = i_apb.psel && i_apb.penable && state.rsp.pready;
    aligned    = (i_apb.paddr[1:0] == 2'h0);
    widx       = i_apb.paddr[7:2];
    rdata      = 32'h00000000;
    wword      = 32'h00000000;
    events     = 4'h0;
    locked_wr  = 1'b0;

    // Eleven clock-controller words plus the interrupt pair.
    mapped = aligned && (i_apb.paddr <= `DPW_OFF_IRQ_MASK);
    if (i_apb.paddr == `DPW_OFF_PWRCTL)
    begin
      rdata = pwrctl_word(state);
    end
    else if (i_apb.paddr == `DPW_OFF_IRQ_STATUS)
    begin
      rdata = {28'h0000000, state.irq_status};
    end
    else if (i_apb.paddr == `DPW_OFF_IRQ_MASK)
    begin
      rdata = {28'h0000000, state.irq_mask};
    end
    else if (mapped)
    begin
      rdata = state.bank[widx - 6'h01];
    end

    // Answer one cycle after setup; zero wait states in the access phase.
    next_state.rsp.pready  = setup;
    next_state.rsp.pslverr = setup && !mapped;
    next_state.rsp.prdata  = (setup && mapped && !i_apb.pwrite) ? rdata : 32'h00000000;

    // Register writes take effect at the completing access edge.
    if (access && i_apb.pwrite && mapped)
    begin
      wword = merge_strb(rdata, i_apb.pwdata, i_apb.pstrb);
      if (i_apb.paddr == `DPW_OFF_PWRCTL)
      begin
        if (i_prot_unlocked)
        begin
          next_state.wake_timer_select         = wword[`DPW_PC_SELECT_LSB +: 4];
          next_state.slow_osc_off_in_deepdown  = wword[`DPW_PC_OSC_OFF];
          next_state.wake_pin_disable          = wword[`DPW_PC_PIN_DIS];
          next_state.deepest_powerdown_request = wword[`DPW_PC_DEEP_REQ];
          next_state.standby_powerdown_request = wword[`DPW_PC_STBY_REQ];
          next_state.osc_enables               = wword[`DPW_PC_OSC_EN_LSB +: 3];
        end
        else
        begin
          locked_wr = 1'b1;
        end
      end
      else if (i_apb.paddr == `DPW_OFF_IRQ_MASK)
      begin
        next_state.irq_mask = wword[3:0];
      end
      else if (i_apb.paddr != `DPW_OFF_IRQ_STATUS)
      begin
        next_state.bank[widx - 6'h01] = wword;
      end
    end

    // Edge detectors run on synchronised pins only.
    next_state.slow_prev = slow_s;
    next_state.pin_prev  = pin_s;
    slow_rise = slow_s && !state.slow_prev;
    pin_fall  = !pin_s && state.pin_prev;
    count_inc = state.slow_count + 11'h001;

    // Any latched select bit whose count is reached fires; none set never fires.
    timer_hit = slow_rise && !state.slow_osc_off_in_deepdown &&
                ((state.wake_timer_status[0] && count_inc == `DPW_WAKE_CNT0) ||
                 (state.wake_timer_status[1] && count_inc == `DPW_WAKE_CNT1) ||
                 (state.wake_timer_status[2] && count_inc == `DPW_WAKE_CNT2) ||
                 (state.wake_timer_status[3] && count_inc == `DPW_WAKE_CNT3));

    // Debug activity or the debug disable bit holds the device out of power-down.
    pd_blocked = i_debug_active || state.bank[9][`DPW_DBG_DISABLE];

    // Power-mode sequencer.
    case (state.mode)
      DPW_RUN:
      begin
        if (i_core_sleep && (state.deepest_powerdown_request ||
                             state.standby_powerdown_request))
        begin
          if (pd_blocked)
          begin
            events[`DPW_IRQ_REFUSED] = 1'b1;
          end
          else if (state.deepest_powerdown_request)
          begin
            next_state.mode               = DPW_DEEP;
            next_state.wake_timer_status  = state.wake_timer_select;
            next_state.power_on_wake_flag = 1'b0;
            next_state.timer_wake_flag    = 1'b0;
            next_state.pin_wake_flag      = 1'b0;
            next_state.slow_count         = 11'h000;
          end
          else
          begin
            next_state.mode = DPW_STANDBY;
          end
        end
      end
      DPW_DEEP:
      begin
        if (slow_rise && !state.slow_osc_off_in_deepdown)
        begin
          next_state.slow_count = count_inc;
        end
        // A power cycle wins over the timer, and the timer over the pin.
        if (por_s)
        begin
          next_state.power_on_wake_flag = 1'b1;
        end
        else if (timer_hit)
        begin
          next_state.timer_wake_flag = 1'b1;
        end
        else if (pin_fall && !state.wake_pin_disable)
        begin
          next_state.pin_wake_flag = 1'b1;
        end
        if (por_s || timer_hit || (pin_fall && !state.wake_pin_disable))
        begin
          next_state.mode                      = DPW_RUN;
          next_state.deepest_powerdown_request = 1'b0;
          events[`DPW_IRQ_DEEP_WAKE]           = 1'b1;
        end
      end
      DPW_STANDBY:
      begin
        if (stby_s || por_s)
        begin
          next_state.mode                      = DPW_RUN;
          next_state.standby_powerdown_request = 1'b0;
          events[`DPW_IRQ_STBY_WAKE]           = 1'b1;
        end
      end
      default:
      begin
        next_state.mode = DPW_RUN;
      end
    endcase

    events[`DPW_IRQ_LOCKED_WR] = locked_wr;

    // Write-one-to-clear, but a new event in the same cycle wins.
    if (access && i_apb.pwrite && i_apb.paddr == `DPW_OFF_IRQ_STATUS && i_apb.pstrb[0])
    begin
      next_state.irq_status = state.irq_status & ~i_apb.pwdata[3:0];
    end
    next_state.irq_status = next_state.irq_status | events;
    next_state.irq        = |(next_state.irq_status & next_state.irq_mask);

    // Power outputs follow the next mode so they come straight from flops.
    next_state.pwr.deepdown_active = (next_state.mode == DPW_DEEP);
    next_state.pwr.standby_active  = (next_state.mode == DPW_STANDBY);
    next_state.pwr.slow_osc_run    = !((next_state.mode == DPW_DEEP) &&
                                       next_state.slow_osc_off_in_deepdown);
    next_state.pwr.fast_osc_enable = next_state.osc_enables[1] &&
                                     (next_state.mode == DPW_RUN);
    next_state.pwr.crystal_enable  = next_state.osc_enables[0];
  end

  // The whole state lives in one register.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= RESET_STATE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs are fields of the state register.
  assign o_apb   = state.rsp;
  assign o_power = state.pwr;
  assign o_irq   = state.irq;

endmodule

`default_nettype wire

// ### verif/dpw_power_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the bus timing and the power-mode entry.
module dpw_power_ctrl_chk
  import dpw_pkg::*;
(
  // Clock and reset.
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // Bus and core status.
  input  wire dpw_pkg::dpw_apb_req_t   i_apb,
  input  wire dpw_pkg::dpw_apb_rsp_t   o_apb,
  input  wire logic                    i_core_sleep,
  input  wire logic                    i_debug_active,
  // Power outputs.
  input  wire dpw_pkg::dpw_power_out_t o_power
);
  import dpw_pkg::*;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // A bus setup cycle, and one that names no register.
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_bad_setup;
    s_setup ##0 (i_apb.paddr > 8'h30 || i_apb.paddr[1:0] != 2'b00);
  endsequence
  sequence s_good_setup;
    s_setup ##0 (i_apb.paddr <= 8'h30 && i_apb.paddr[1:0] == 2'b00);
  endsequence

  // Bus answers one cycle after setup and only for one cycle.
  a_ready_after_setup: assert property (s_setup |=> o_apb.pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready longer than one cycle");
  a_ready_has_cause: assert property ($rose(o_apb.pready) |-> $past(i_apb.psel))
    else $error("ready without request");
  a_unmapped_error: assert property (s_bad_setup |=> o_apb.pslverr)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (s_good_setup |=> !o_apb.pslverr)
    else $error("mapped access refused");
  // Read data is cleared outside the answer cycle so stale values never leak.
  a_idle_data_zero: assert property (!o_apb.pready |-> o_apb.prdata == 32'h00000000)
    else $error("read data outside answer");

  // A power mode is entered only on a core sleep, never under debug.
  a_entry_on_sleep: assert property ($rose(o_power.deepdown_active) |-> $past(i_core_sleep))
    else $error("deep entry without sleep");
  a_stby_on_sleep: assert property ($rose(o_power.standby_active) |-> $past(i_core_sleep))
    else $error("standby entry without sleep");
  a_debug_blocks: assert property (i_core_sleep && i_debug_active |=>
    !$rose(o_power.deepdown_active) && !$rose(o_power.standby_active))
    else $error("entry while debug active");
  a_one_mode: assert property (!(o_power.deepdown_active && o_power.standby_active))
    else $error("two modes at once");
endmodule

bind dpw_power_ctrl dpw_power_ctrl_chk u_chk (
  .i_clk          (i_clk),
  .i_resetn       (i_resetn),
  .i_apb          (i_apb),
  .o_apb          (o_apb),
  .i_core_sleep   (i_core_sleep),
  .i_debug_active (i_debug_active),
  .o_power        (o_power)
);

`default_nettype wire

// ### verif/deep_power_down_wake_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module deep_power_down_wake_control_bench;
  import dpw_pkg::*;
  // Stimulus, observed outputs and bookkeeping.
  logic           i_clk      = 1'b0;
  logic           i_resetn   = 1'b0;
  dpw_apb_req_t   req        = '0;
  dpw_apb_rsp_t   rsp;
  logic           unlocked   = 1'b0;
  logic           sleep      = 1'b0;
  logic           debug      = 1'b0;
  logic           pin        = 1'b1;
  logic           osc        = 1'b0;
  logic           por        = 1'b0;
  logic           stby_wake  = 1'b0;
  dpw_power_out_t pwr;
  logic           irq;
  logic [31:0]    rd;
  logic           err;
  logic [3:0]     sel;
  logic [7:0]     adr;
  logic [31:0]    wdat;
  int             num_errors = 0;
  int             checks     = 0;
  logic [31:0]    rst_tab [11] = '{32'h00000006, 32'h00000005, 32'h0, 32'h0, 32'h00000038,
    32'h3300771f, 32'h0, 32'hfffffff0, 32'h0fffffff, 32'h0, 32'h0};

  // System clock at 25 MHz.
  always #20 i_clk = ~i_clk;

  dpw_power_ctrl dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_apb(req), .o_apb(rsp),
    .i_prot_unlocked(unlocked), .i_core_sleep(sleep), .i_debug_active(debug),
    .i_wake_pin(pin), .i_slow_osc_clk(osc), .i_por_event(por),
    .i_standby_wake(stby_wake), .o_power(pwr), .o_irq(irq));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // Power-control word; bits 2:1 stay set so the oscillators keep their reset state.
  function automatic logic [31:0] pc(input logic [3:0] s, input logic off, dis, dp, sb);
    return {8'h00, s, 2'b00, off, dis, 4'h0, dp, sb, 10'h006};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One bus transfer; the request holds until ready is seen at an edge.
  // Only the watchdog ends a wait for ready, so a hang is counted as a mismatch.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hf};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
    end
    while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Slow oscillator cycles, long enough for the synchroniser to see each edge.
  task automatic slow(input int n);
    repeat (n)
    begin
      osc <= 1'b1;
      cyc(3);
      osc <= 1'b0;
      cyc(3);
    end
  endtask

  task automatic enter(input logic [31:0] w);
    apb(1'b1, 8'h00, w);
    @(posedge i_clk);
    sleep <= 1'b1;
    @(posedge i_clk);
    sleep <= 1'b0;
    cyc(2);
  endtask

  // Waits a bounded time for both power modes to drop.
  task automatic wake_wait();
    int n;
    n = 0;
    while ((pwr.deepdown_active | pwr.standby_active) !== 1'b0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(n < 20, "no wakeup");
  endtask

  task end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog sized well above the longest timer scenarios.
  initial
  begin
    cyc(60000);
    num_errors++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'hdfff));
    cyc(4);
    i_resetn <= 1'b1;
    cyc(2);
    chk(pwr.slow_osc_run === 1'b1 && pwr.fast_osc_enable === 1'b1, "clocks after reset");
    chk(pwr.crystal_enable === 1'b1 && irq === 1'b0, "outputs after reset");
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd === rst_tab[i] && err === 1'b0, "reset value");
    end
    apb(1'b0, 8'h34, 32'h0);
    chk(err === 1'b1, "offset past map");
    apb(1'b0, 8'h02, 32'h0);
    chk(err === 1'b1, "unaligned offset");
    repeat (8)
    begin
      adr  = 8'(4 * (1 + $urandom_range(8)));
      wdat = $urandom;
      apb(1'b1, adr, wdat);
      apb(1'b0, adr, 32'h0);
      chk(rd === wdat, "storage readback");
    end
    apb(1'b1, 8'h00, pc(4'h1, 1'b0, 1'b0, 1'b1, 1'b0));
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h00000006, "locked write");
    apb(1'b1, 8'h30, 32'h00000008);
    cyc(2);
    chk(irq === 1'b1, "locked write interrupt");
    apb(1'b1, 8'h2c, 32'h00000008);
    cyc(2);
    chk(irq === 1'b0, "interrupt clear");
    unlocked <= 1'b1;
    debug    <= 1'b1;
    enter(pc(4'h1, 1'b0, 1'b0, 1'b1, 1'b0));
    chk(pwr.deepdown_active === 1'b0, "entry under debug");
    debug <= 1'b0;
    // The debug disable bit must hold the device awake just like live debug.
    apb(1'b1, 8'h28, 32'h00000001);
    enter(pc(4'h1, 1'b0, 1'b0, 1'b1, 1'b0));
    chk(pwr.deepdown_active === 1'b0, "entry under disable bit");
    apb(1'b1, 8'h28, 32'h00000000);
    // Timed wake for each select bit; higher bits set at random must not matter.
    for (int k = 0; k < 4; k++)
    begin
      sel = (4'h1 << k) | (4'($urandom) << (k + 1));
      enter(pc(sel, 1'b0, 1'b1, 1'b1, 1'b0));
      chk(pwr.deepdown_active === 1'b1, "deep entry");
      chk(pwr.slow_osc_run === 1'b1 && pwr.fast_osc_enable === 1'b0, "clocks in deep");
      pin <= 1'b0;
      cyc(6);
      pin <= 1'b1;
      chk(pwr.deepdown_active === 1'b1, "disabled pin woke");
      apb(1'b0, 8'h00, 32'h0);
      chk(rd[31:24] === {sel, 4'h0}, "status on entry");
      slow((128 << k) - 1);
      chk(pwr.deepdown_active === 1'b1, "early timed wake");
      slow(1);
      wake_wait();
      apb(1'b0, 8'h00, 32'h0);
      chk(rd[25] === 1'b1 && rd[11] === 1'b0, "timer flag");
    end
    enter(pc(4'h0, 1'($urandom), 1'b0, 1'b1, 1'b0));
    slow(1030);
    chk(pwr.deepdown_active === 1'b1, "wake without select");
    pin <= 1'b0;
    wake_wait();
    pin <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[26:24] === 3'b001, "pin flag");
    enter(pc(4'h1, 1'b1, 1'b0, 1'b1, 1'b0));
    slow(200);
    chk(pwr.deepdown_active === 1'b1 && pwr.slow_osc_run === 1'b0, "oscillator off");
    por <= 1'b1;
    wake_wait();
    por <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[26:24] === 3'b100, "power-on flag");
    enter(pc(4'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    chk(pwr.standby_active === 1'b1 && pwr.deepdown_active === 1'b0, "standby");
    stby_wake <= 1'b1;
    wake_wait();
    stby_wake <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[11:10] === 2'b00, "request bits after wake");
    // Deep wake, standby wake and refusal are latched; the locked-write bit was cleared.
    apb(1'b0, 8'h2c, 32'h0);
    chk(rd === 32'h00000007 && irq === 1'b0, "event status");
    end_of_test();
  end
endmodule

`default_nettype wire
